// ---- src/flash_call_cfg.svh ----
// constants of the flash system-call handler
`ifndef FLASH_CALL_CFG_SVH
`define FLASH_CALL_CFG_SVH
// apb byte offsets
`define ADDR_ARG 12'h000
`define ADDR_REQ 12'h004
`define ADDR_CTRL 12'h008
// unlock bytes and operation codes
`define FIRST_UNLOCK_BYTE 8'hB6
`define SECOND_UNLOCK_BYTE_PROG 8'hD9
`define SECOND_UNLOCK_BYTE_ERASE 8'hDD
`define SECOND_UNLOCK_BYTE_SUM 8'hDE
`define OP_PROG 16'h0006
`define OP_ERASE 16'h000A
`define OP_SUM 16'h000B
`define OP_FIELD 15:0
`define REQ_BIT 31
// argument fields
`define FIRST_UNLOCK_BYTE_FIELD 7:0
`define SECOND_UNLOCK_BYTE_FIELD 15:8
`define SEL_FIELD 31:16
`define STATUS_FIELD 31:28
`define SEL_WHOLE 16'h8000
`define ST_OK 4'hA
`define ST_FAIL 4'hF
`define ST_PAD 4'h0
`define SUM_ZERO 24'h000000
// control register fields
`define CTRL_W 4
`define CTRL_DBG 0
`define CTRL_PGM 1
`define CTRL_PROT 3:2
`define PROT_OPEN 2'h1
`define PROT_PROT 2'h2
// flash geometry
`define ROWS 8
`define ROW_COUNT 16'h0008
`define ROW_MSB 2
`define ROW_BYTES 128
`define BYTE_BITS 7
`define PROT_PER_BYTE 8
`define TOTAL_BYTES 1152
`define SUP_BASE 1024
`define IDX_W 11
`define IDX_ZERO 11'h000
`define IDX_ONE 11'h001
`define IDX_LAST_ALL 11'h47F
`define ERASED 8'h00
`endif

// ---- src/flash_call_pkg.sv ----
// types of the flash system-call handler
package flash_call_pkg;
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_FETCH = 8'h02,
		S_DECODE = 8'h04,
		S_PROG = 8'h08,
		S_CLEAR = 8'h10,
		S_ERASE = 8'h20,
		S_SUM = 8'h40,
		S_DONE = 8'h80
	} state_e;
endpackage

// ---- src/flash_row_store.sv ----
// user rows plus supervisory row, one byte port each way
`timescale 1ns/100ps
`include "flash_call_cfg.svh"
module flash_row_store (
	// clock
	input wire logic clk,
	// byte write and bulk erase
	input wire logic wr_en,
	input wire logic [`IDX_W-1:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic erase_all,
	// byte read
	input wire logic [`IDX_W-1:0] rd_idx,
	output logic [7:0] rd_data,
	// row protection bits from supervisory row
	output logic [`ROWS-1:0] prot_bits
);
	// nonvolatile contents: deliberately not cleared by reset
	logic [7:0] mem [0:`TOTAL_BYTES-1];

	always_ff @(posedge clk) begin
		if (erase_all) begin
			for (int i = 0; i < `TOTAL_BYTES; i++) begin
				mem[i] <= `ERASED;
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign rd_data = mem[rd_idx];

	genvar g;
	generate
		for (g = 0; g < `ROWS; g++) begin : g_prot
			assign prot_bits[g] =
				mem[`SUP_BASE + g / `PROT_PER_BYTE][g % `PROT_PER_BYTE];
		end
	endgenerate
endmodule

// ---- src/flash_row_program_erase_checksum.sv ----
// system-call handler: row program, erase all, checksum over apb
//
// Behaviour
// - all-zero latch skips row programming
// - latch is cleared after row programming
// - write-protected rows are never programmed
// - program keys B6/D9, row field, code 0006
// - argument holds address of key word
// - erase all wipes user and protection rows
// - erase all call only debug, programming, open
// - protected to open forces erase all
// - checksum keys B6/DE, 24-bit byte sum
// - whole checksum includes supervisory row
// - checksum keys and selector in argument
// - selector 8000 whole, else row number
// - checksum result in argument bits 23:0
`timescale 1ns/100ps
`include "flash_call_cfg.svh"
module flash_row_program_erase_checksum (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// parameter word fetch
	output logic MEM_REQ,
	output logic [31:0] MEM_ADDR,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_ACK,
	// page latch loading
	input wire logic LATCH_WE,
	input wire logic [`BYTE_BITS-1:0] LATCH_IDX,
	input wire logic [7:0] LATCH_DATA,
	// status
	output logic CALL_BUSY
);
	flash_call_pkg::state_e state_reg, state_next;
	logic [31:0] arg_reg, req_reg, key_reg, rdata_reg;
	logic [`CTRL_W-1:0] ctrl_reg;
	logic [15:0] op_reg;
	logic [23:0] sum_reg;
	logic [`IDX_W-1:0] idx_reg, end_reg, row_base, row_last;
	logic [`ROW_MSB:0] row_reg;
	logic ok_reg, auto_reg, pass;
	logic [7:0] latch [0:`ROW_BYTES-1];
	logic latch_zero;
	logic wr_acc, rd_setup, hit_arg, hit_req, hit_ctrl, idle;
	logic call_start, auto_start, keys_ok, row_ok, whole;
	logic [7:0] second_unlock_byte_exp, rd_data;
	logic [15:0] sel;
	logic [`ROWS-1:0] prot_bits;
	logic st_wr_en, erase_all;

	// apb decode; zero wait states, so a transfer is setup plus access
	assign wr_acc = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign hit_arg = PADDR == `ADDR_ARG;
	assign hit_req = PADDR == `ADDR_REQ;
	assign hit_ctrl = PADDR == `ADDR_CTRL;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !(hit_arg || hit_req || hit_ctrl);
	assign PRDATA = rdata_reg;
	assign idle = state_reg == flash_call_pkg::S_IDLE;
	assign CALL_BUSY = !idle;

	assign call_start = wr_acc && hit_req && idle && PWDATA[`REQ_BIT];
	assign auto_start = wr_acc && hit_ctrl && idle
		&& ctrl_reg[`CTRL_PROT] == `PROT_PROT
		&& PWDATA[`CTRL_PROT] == `PROT_OPEN;

	// parameter word decode
	assign sel = key_reg[`SEL_FIELD];
	assign whole = sel == `SEL_WHOLE;
	assign row_ok = sel < `ROW_COUNT;
	assign row_base = {1'b0, sel[`ROW_MSB:0], {`BYTE_BITS{1'b0}}};
	assign row_last = {1'b0, sel[`ROW_MSB:0], {`BYTE_BITS{1'b1}}};

	always_comb begin
		case (op_reg)
			`OP_PROG: second_unlock_byte_exp = `SECOND_UNLOCK_BYTE_PROG;
			`OP_ERASE: second_unlock_byte_exp = `SECOND_UNLOCK_BYTE_ERASE;
			`OP_SUM: second_unlock_byte_exp = `SECOND_UNLOCK_BYTE_SUM;
			default: second_unlock_byte_exp = `ERASED;
		endcase
	end

	assign keys_ok = key_reg[`FIRST_UNLOCK_BYTE_FIELD] == `FIRST_UNLOCK_BYTE
		&& key_reg[`SECOND_UNLOCK_BYTE_FIELD] == second_unlock_byte_exp;

	// latch may only be loaded between calls, so its sweep is a single OR
	always_comb begin
		latch_zero = 1'b1;
		for (int i = 0; i < `ROW_BYTES; i++) begin
			if (latch[i] != `ERASED) begin
				latch_zero = 1'b0;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		pass = 1'b0;
		case (state_reg)
			flash_call_pkg::S_IDLE: begin
				if (auto_start) begin
					state_next = flash_call_pkg::S_ERASE;
				end else if (call_start) begin
					case (PWDATA[`OP_FIELD])
						`OP_SUM: state_next = flash_call_pkg::S_DECODE;
						`OP_PROG, `OP_ERASE: state_next = flash_call_pkg::S_FETCH;
						default: state_next = flash_call_pkg::S_DONE;
					endcase
				end
			end
			flash_call_pkg::S_FETCH: begin
				if (MEM_ACK) begin
					state_next = flash_call_pkg::S_DECODE;
				end
			end
			flash_call_pkg::S_DECODE: begin
				state_next = flash_call_pkg::S_DONE;
				case (op_reg)
					`OP_PROG: begin
						pass = keys_ok && row_ok
							&& !prot_bits[sel[`ROW_MSB:0]];
						if (pass && !latch_zero) begin
							state_next = flash_call_pkg::S_PROG;
						end
					end
					`OP_ERASE: begin
						pass = keys_ok && ctrl_reg[`CTRL_DBG]
							&& ctrl_reg[`CTRL_PGM]
							&& ctrl_reg[`CTRL_PROT] == `PROT_OPEN;
						if (pass) begin
							state_next = flash_call_pkg::S_ERASE;
						end
					end
					`OP_SUM: begin
						pass = keys_ok && (whole || row_ok);
						if (pass) begin
							state_next = flash_call_pkg::S_SUM;
						end
					end
					default: pass = 1'b0;
				endcase
			end
			flash_call_pkg::S_PROG: begin
				if (idx_reg == end_reg) begin
					state_next = flash_call_pkg::S_CLEAR;
				end
			end
			flash_call_pkg::S_CLEAR: state_next = flash_call_pkg::S_DONE;
			flash_call_pkg::S_ERASE: state_next = flash_call_pkg::S_DONE;
			flash_call_pkg::S_SUM: begin
				if (idx_reg == end_reg) begin
					state_next = flash_call_pkg::S_DONE;
				end
			end
			flash_call_pkg::S_DONE: state_next = flash_call_pkg::S_IDLE;
			default: state_next = flash_call_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= flash_call_pkg::S_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// call bookkeeping
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			op_reg <= 16'h0000;
			ok_reg <= 1'b0;
			auto_reg <= 1'b0;
		end else if (auto_start) begin
			op_reg <= `OP_ERASE;
			ok_reg <= 1'b1;
			auto_reg <= 1'b1;
		end else if (call_start) begin
			op_reg <= PWDATA[`OP_FIELD];
			ok_reg <= 1'b0;
			auto_reg <= 1'b0;
		end else if (state_reg == flash_call_pkg::S_DECODE) begin
			ok_reg <= pass;
		end
	end

	// key word comes from memory for program and erase, from argument else
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			key_reg <= 32'h00000000;
		end else if (call_start) begin
			key_reg <= arg_reg;
		end else if (state_reg == flash_call_pkg::S_FETCH && MEM_ACK) begin
			key_reg <= MEM_RDATA;
		end
	end

	assign MEM_REQ = state_reg == flash_call_pkg::S_FETCH;
	assign MEM_ADDR = arg_reg;

	// byte walk: row range or whole flash including supervisory row
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			idx_reg <= `IDX_ZERO;
			end_reg <= `IDX_ZERO;
			row_reg <= '0;
		end else if (state_reg == flash_call_pkg::S_DECODE) begin
			idx_reg <= whole && op_reg == `OP_SUM ? `IDX_ZERO : row_base;
			end_reg <= whole && op_reg == `OP_SUM ?
				`IDX_LAST_ALL : row_last;
			row_reg <= sel[`ROW_MSB:0];
		end else if (state_reg == flash_call_pkg::S_PROG
			|| state_reg == flash_call_pkg::S_SUM) begin
			idx_reg <= idx_reg + `IDX_ONE;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sum_reg <= `SUM_ZERO;
		end else if (call_start) begin
			sum_reg <= `SUM_ZERO;
		end else if (state_reg == flash_call_pkg::S_SUM) begin
			sum_reg <= sum_reg + {16'h0000, rd_data};
		end
	end

	// page latch
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < `ROW_BYTES; i++) begin
				latch[i] <= `ERASED;
			end
		end else if (state_reg == flash_call_pkg::S_CLEAR) begin
			for (int i = 0; i < `ROW_BYTES; i++) begin
				latch[i] <= `ERASED;
			end
		end else if (LATCH_WE && idle) begin
			latch[LATCH_IDX] <= LATCH_DATA;
		end
	end

	assign st_wr_en = state_reg == flash_call_pkg::S_PROG;
	assign erase_all = state_reg == flash_call_pkg::S_ERASE;

	flash_row_store u_store (
		.clk(CLK),
		.wr_en(st_wr_en),
		.wr_idx(idx_reg),
		.wr_data(latch[idx_reg[`BYTE_BITS-1:0]]),
		.erase_all(erase_all),
		.rd_idx(idx_reg),
		.rd_data(rd_data),
		.prot_bits(prot_bits)
	);

	// software registers; argument and request are frozen during a call
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			arg_reg <= 32'h00000000;
		end else if (state_reg == flash_call_pkg::S_DONE) begin
			arg_reg <= {ok_reg ? `ST_OK : `ST_FAIL, `ST_PAD,
				ok_reg && op_reg == `OP_SUM ? sum_reg : `SUM_ZERO};
		end else if (wr_acc && hit_arg && idle) begin
			arg_reg <= PWDATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			req_reg <= 32'h00000000;
		end else if (state_reg == flash_call_pkg::S_DONE) begin
			req_reg[`REQ_BIT] <= 1'b0;
		end else if (wr_acc && hit_req && idle) begin
			req_reg <= PWDATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_reg <= '0;
		end else if (wr_acc && hit_ctrl && idle) begin
			ctrl_reg <= PWDATA[`CTRL_W-1:0];
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_reg <= 32'h00000000;
		end else if (rd_setup) begin
			rdata_reg <= hit_arg ? arg_reg : hit_req ? req_reg
				: hit_ctrl ? {28'h0000000, ctrl_reg} : 32'h00000000;
		end
	end

	AST_SKIP_ZERO: assert property (@(posedge CLK) disable iff (!RST_B)
		st_wr_en |-> !latch_zero)
		else $error("row programmed from an all-zero latch");
	AST_LATCH_CLEAR: assert property (@(posedge CLK) disable iff (!RST_B)
		st_wr_en && !$past(st_wr_en) |-> ##128 state_reg
		== flash_call_pkg::S_CLEAR ##1 latch_zero)
		else $error("latch not cleared after programming");
	AST_PROTECT: assert property (@(posedge CLK) disable iff (!RST_B)
		st_wr_en |-> !prot_bits[row_reg])
		else $error("protected row written");
	AST_PROG_KEYS: assert property (@(posedge CLK) disable iff (!RST_B)
		st_wr_en |-> key_reg[`FIRST_UNLOCK_BYTE_FIELD] == `FIRST_UNLOCK_BYTE
		&& key_reg[`SECOND_UNLOCK_BYTE_FIELD] == `SECOND_UNLOCK_BYTE_PROG)
		else $error("program ran without its keys");
	AST_ERASE_GATE: assert property (@(posedge CLK) disable iff (!RST_B)
		erase_all && !auto_reg |-> ctrl_reg[`CTRL_DBG]
		&& ctrl_reg[`CTRL_PGM] && ctrl_reg[`CTRL_PROT] == `PROT_OPEN)
		else $error("erase all outside debug open mode");
	AST_AUTO_ERASE: assert property (@(posedge CLK) disable iff (!RST_B)
		auto_start |-> ##1 erase_all ##2 arg_reg[`STATUS_FIELD] == `ST_OK)
		else $error("unlock did not erase");
	AST_WHOLE_RANGE: assert property (@(posedge CLK) disable iff (!RST_B)
		state_reg == flash_call_pkg::S_DECODE && op_reg == `OP_SUM
		&& keys_ok && whole |=> idx_reg == `IDX_ZERO
		&& end_reg == `IDX_LAST_ALL)
		else $error("whole checksum range wrong");
	AST_SUM_RESULT: assert property (@(posedge CLK) disable iff (!RST_B)
		state_reg == flash_call_pkg::S_DONE && ok_reg && op_reg == `OP_SUM
		|=> arg_reg[23:0] == $past(sum_reg) && !CALL_BUSY)
		else $error("checksum not returned");
	AST_BAD_KEYS: assert property (@(posedge CLK) disable iff (!RST_B)
		state_reg == flash_call_pkg::S_DECODE && !keys_ok
		|-> ##1 (!st_wr_en && !erase_all)
		##1 arg_reg[`STATUS_FIELD] == `ST_FAIL)
		else $error("bad keys not refused");
	AST_REQ_DONE: assert property (@(posedge CLK) disable iff (!RST_B)
		call_start |=> req_reg[`REQ_BIT] && CALL_BUSY)
		else $error("request bit not held while busy");
endmodule

// ---- testbench/param_word_memory.sv ----
// parameter word memory answering the handler's fetch port
`timescale 1ns/100ps
module param_word_memory (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// fetch port
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [31:0] mem_rdata,
	// stored word, its address and answer delay
	input wire logic [31:0] base,
	input wire logic [31:0] word,
	input wire logic [3:0] lat
);
	logic [3:0] cnt_reg;
	// data toggles outside a request so a stale word never passes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'hFFFFFFFF;
			cnt_reg <= 4'h0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && cnt_reg == lat) begin
			mem_ack <= 1'b1;
			cnt_reg <= 4'h0;
			// key word only at the address held in the argument
			mem_rdata <= (mem_addr == base) ? word : ~word;
		end else if (mem_req) begin
			cnt_reg <= cnt_reg + 4'h1;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

// ---- testbench/flash_row_program_erase_checksum_tb.sv ----
// testbench of the flash system-call handler
`timescale 1ns/100ps
`include "flash_call_cfg.svh"
module flash_row_program_erase_checksum_tb;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h00000000;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic MEM_REQ;
	logic [31:0] MEM_ADDR;
	logic [31:0] MEM_RDATA;
	logic MEM_ACK;
	logic LATCH_WE = 1'b0;
	logic [6:0] LATCH_IDX = 7'h00;
	logic [7:0] LATCH_DATA = 8'h00;
	logic CALL_BUSY;
	logic [31:0] word = 32'h00000000;
	logic [3:0] lat = 4'h0;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int checked = 0;
	localparam logic [31:0] OK = 32'hA0000000;
	localparam logic [31:0] BAD = 32'hF0000000;
	localparam logic [31:0] KEYADDR = 32'h00000010;
	always #50 CLK = ~CLK;
	flash_row_program_erase_checksum DUT (.CLK(CLK), .RST_B(RST_B),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
		.MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .LATCH_WE(LATCH_WE),
		.LATCH_IDX(LATCH_IDX), .LATCH_DATA(LATCH_DATA),
		.CALL_BUSY(CALL_BUSY));
	param_word_memory MEM (.clk(CLK), .rst_b(RST_B), .mem_req(MEM_REQ),
		.mem_addr(MEM_ADDR), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA),
		.base(KEYADDR), .word(word), .lat(lat));
	function automatic logic [31:0] kw(logic [15:0] sel, logic [7:0] k2);
		return {sel, k2, `FIRST_UNLOCK_BYTE};
	endfunction
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		if (PREADY !== 1'b1) begin
			fail_count++;
			$display("unexpected pready: expected 1, seen 0");
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		@(negedge CLK);
		while (CALL_BUSY === 1'b1 && n < 2000) begin
			@(negedge CLK);
			n++;
		end
		if (n >= 2000) begin
			fail_count++;
			$display("unexpected busy: expected 0, seen 1");
		end
	endtask
	task automatic call(logic [31:0] a, logic [15:0] op, logic [31:0] exp);
		apb(1'b1, `ADDR_ARG, a);
		apb(1'b1, `ADDR_REQ, {16'h8000, op});
		wait_done();
		apb(1'b0, `ADDR_ARG, 32'h0);
		chk("argument", exp, rd);
		apb(1'b0, `ADDR_REQ, 32'h0);
		chk("request", {16'h0000, op}, rd);
	endtask
	task automatic load();
		for (int i = 0; i < 128; i++) begin
			@(posedge CLK);
			LATCH_WE <= 1'b1;
			LATCH_IDX <= i[6:0];
			LATCH_DATA <= i[7:0] + 8'h01;
		end
		@(posedge CLK);
		LATCH_WE <= 1'b0;
	endtask
	task automatic t_reset();
		apb(1'b0, `ADDR_ARG, 32'h0);
		chk("argument", 32'h0, rd);
		apb(1'b0, `ADDR_REQ, 32'h0);
		chk("request", 32'h0, rd);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
	endtask
	task automatic t_unlock();
		apb(1'b1, `ADDR_CTRL, 32'h8);
		apb(1'b1, `ADDR_CTRL, 32'h7);
		wait_done();
		apb(1'b0, `ADDR_ARG, 32'h0);
		chk("argument", OK, rd);
		call(kw(`SEL_WHOLE, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, OK);
	endtask
	task automatic t_program();
		load();
		word <= kw(16'h0002, `SECOND_UNLOCK_BYTE_PROG);
		call(KEYADDR, `OP_PROG, OK);
		call(kw(16'h0002, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, 32'hA0002040);
		call(kw(`SEL_WHOLE, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, 32'hA0002040);
		word <= kw(16'h0003, `SECOND_UNLOCK_BYTE_PROG);
		call(KEYADDR, `OP_PROG, OK);
		call(kw(16'h0003, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, OK);
	endtask
	task automatic t_refuse();
		load();
		lat <= 4'h3;
		word <= kw(16'h0004, 8'hD8);
		call(KEYADDR, `OP_PROG, BAD);
		call(kw(16'h0004, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, OK);
		call({16'h0002, `SECOND_UNLOCK_BYTE_SUM, 8'hB7}, `OP_SUM, BAD);
		call(kw(16'h0008, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, BAD);
		call(kw(16'h0002, `SECOND_UNLOCK_BYTE_PROG), `OP_SUM, BAD);
		call(kw(16'h0002, `SECOND_UNLOCK_BYTE_SUM), 16'h0005, BAD);
	endtask
	task automatic t_erase();
		apb(1'b1, `ADDR_CTRL, 32'h6);
		word <= kw(16'h0000, `SECOND_UNLOCK_BYTE_ERASE);
		call(KEYADDR, `OP_ERASE, BAD);
		call(kw(16'h0002, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, 32'hA0002040);
		apb(1'b1, `ADDR_CTRL, 32'h7);
		word <= kw(16'h0000, `SECOND_UNLOCK_BYTE_SUM);
		call(KEYADDR, `OP_ERASE, BAD);
		word <= kw(16'h0000, `SECOND_UNLOCK_BYTE_ERASE);
		call(KEYADDR, `OP_ERASE, OK);
		call(kw(16'h0002, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, OK);
		call(kw(`SEL_WHOLE, `SECOND_UNLOCK_BYTE_SUM), `OP_SUM, OK);
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// whole run is some 5000 cycles, so this only trips on a hang
	initial begin
		#3000000;
		fail_count++;
		$display("unexpected watchdog: expected end, seen hang");
		end_sim();
	end
	initial begin
		repeat (6) @(posedge CLK);
		RST_B <= 1'b1;
		t_reset();
		t_unlock();
		t_program();
		t_refuse();
		t_erase();
		end_sim();
	end
endmodule
